// File: core/gsf_pkg.sv
package gsf_pkg;

    // ==========================================
    // Sizes
    localparam int unsigned NUM_GPI = 32;
    localparam int unsigned NUM_RAIL = 32;
    localparam int unsigned ADDR_W = 8;

    // ==========================================
    // Register byte offsets
    localparam logic [7:0] OFS_POLARITY = 8'h00;
    localparam logic [7:0] OFS_FAULT_EN = 8'h04;
    localparam logic [7:0] OFS_ROLE = 8'h08;
    localparam logic [7:0] OFS_FPIN_EN = 8'h0c;
    localparam logic [7:0] OFS_FPIN_RAILS = 8'h10;
    localparam logic [7:0] OFS_MARGIN_RAILS = 8'h14;
    localparam logic [7:0] OFS_GPI_STATE = 8'h18;
    localparam logic [7:0] OFS_EVT_LATCH = 8'h1c;
    localparam logic [7:0] OFS_MODE = 8'h20;

    // ==========================================
    // Role register fields: index in [4:0] of each byte, enable at bit 5
    localparam int unsigned ROLE_CLEAR_POS = 0;
    localparam int unsigned ROLE_MEN_POS = 8;
    localparam int unsigned ROLE_MDIR_POS = 16;
    localparam int unsigned ROLE_DEBUG_POS = 24;
    localparam int unsigned ROLE_EN_BIT = 5;

    // ==========================================
    // Reset values
    localparam logic [31:0] POLARITY_RST = 32'hffff_ffff;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;

    // ==========================================
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int unsigned NUM_EVT = 18;

    typedef struct packed {
        logic seuDetected;
        logic slaveShutdown;
        logic seqOffTimeout;
        logic seqOnTimeout;
        logic resequenceError;
        logic watchdogTimeout;
        logic gpiDeasserted;
        logic overTempWarn;
        logic overTempFault;
        logic underCurrentFault;
        logic overCurrentWarn;
        logic overCurrentFault;
        logic turn_off_time_limit_warning;
        logic turn_on_time_limit_fault;
        logic underVoltWarn;
        logic underVoltFault;
        logic overVoltWarn;
        logic overVoltFault;
    } gsf_event_type;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_ADDR = 2'b01,
        WR_RESP = 2'b11,
        WR_DATA = 2'b10
    } gsf_wr_state_type;

endpackage

// File: core/gsf_gpi_special.sv
// Behaviour
// - Each input has selectable polarity; for outputs it picks the true level.
// - Open-drain high output is a released pin, pulled up externally.
// - With fault enable set, a de-asserted input raises a fault.
// - Clear-source input assertion clears all latched statuses.
// - With margin enable asserted, margin-direction input picks low or high.
// - Margin enable asserted puts every margin-enabled rail into margin.
// - Direction asserted means low, de-asserted high; each role on one input.
// - Debug input asserted: never raise bus alert for faults or warnings.
// - Debug active: no fault response and no fault logging.
// - Communication errors still reach the alert during debug.
// - Debug ignores rail dependencies and stops fault pins pulling bus low.
// - A fault pin reflects any fault on its selected rails.
// - Fault pin listens to the bus, drives low on fault when active-low (polarity 0), then releases.
// - Suppressed set holds voltage, current and temperature faults and warnings.
// - Turn-on time limit fault is part of the suppressed set.
// - Turn-off time limit warning is part of the suppressed set.
// - Debug skips log and response for de-asserted inputs, keeps other roles.
// - Sequence on and off timeouts are part of the suppressed set.
// - Dependent-rail shutdown is part of the suppressed set.
// - Config upset, resequence failure and watchdog are distinct suppressed events.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
module gsf_gpi_special (
    input wire logic core_clk,
    input wire logic sys_rst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and system events
    input wire logic [31:0] gpiPinIn,
    output logic [31:0] gpiPinOut,
    output logic [31:0] gpiPinOe,
    input wire logic [31:0] railFault,
    input wire gsf_pkg::gsf_event_type railEvents,
    input wire logic cmlError,
    output logic alertReq,
    output gsf_pkg::gsf_event_type logEvents,
    output gsf_pkg::gsf_event_type respondEvents,
    output logic [31:0] railMargined,
    output logic marginLow,
    output logic latchClear,
    output logic debugActive,
    output logic [31:0] gpiAsserted
);

    // ==========================================
    // Configuration and state
    logic [31:0] polarity_reg, polarity_next;
    logic [31:0] faultEn_reg, faultEn_next;
    logic [31:0] role_reg, role_next;
    logic [31:0] fpinEn_reg, fpinEn_next;
    logic [31:0] fpinRails_reg, fpinRails_next;
    logic [31:0] marginRails_reg, marginRails_next;
    logic [17:0] evtLatch_reg, evtLatch_next;
    logic [17:0] evtPrev_reg, evtPrev_next;
    logic [31:0] syncA_reg, syncB_reg;
    logic [31:0] asserted_reg, asserted_next;
    logic [31:0] pinOe_reg, pinOe_next;
    logic [31:0] railMarg_reg, railMarg_next;
    logic marginLow_reg, marginLow_next;
    logic latchClear_reg, latchClear_next;
    logic debug_reg, debug_next;
    logic alert_reg, alert_next;
    logic [17:0] log_reg, log_next;
    logic [17:0] resp_reg, resp_next;

    // Bus slave state
    gsf_pkg::gsf_wr_state_type wrState_reg, wrState_next;
    logic [7:0] wrAddr_reg, wrAddr_next;
    logic [31:0] wrData_reg, wrData_next;
    logic [3:0] wrStrb_reg, wrStrb_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    // ==========================================
    // Combinational helpers
    logic [31:0] gpiTrue;
    logic clearAct, menAct, mdirAct, debugAct;
    logic [17:0] evtVec;
    logic anyFpinFault;
    logic wrFire;

    function automatic logic roleHit(input logic [31:0] role, input int unsigned pos, input logic [31:0] st);
        logic [4:0] idx;
        idx = role[pos +: 5];
        return role[pos + gsf_pkg::ROLE_EN_BIT] && st[idx];
    endfunction

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] din, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = din[8*i +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        // Polarity applied on the second sync stage only
        gpiTrue = syncB_reg ^ ~polarity_reg;
        // Each role names a single input index, so two inputs can never share it
        clearAct = roleHit(role_reg, gsf_pkg::ROLE_CLEAR_POS, asserted_reg);
        menAct = roleHit(role_reg, gsf_pkg::ROLE_MEN_POS, asserted_reg);
        mdirAct = roleHit(role_reg, gsf_pkg::ROLE_MDIR_POS, asserted_reg);
        debugAct = roleHit(role_reg, gsf_pkg::ROLE_DEBUG_POS, asserted_reg);
        evtVec = railEvents;
        // Fault-enabled inputs that are not asserted count as faults
        evtVec[11] = railEvents.gpiDeasserted | (|(faultEn_reg & ~asserted_reg));
        anyFpinFault = |(railFault & fpinRails_reg);
    end

    // ==========================================
    // Special function next state
    always_comb begin
        polarity_next = polarity_reg;
        faultEn_next = faultEn_reg;
        role_next = role_reg;
        fpinEn_next = fpinEn_reg;
        fpinRails_next = fpinRails_reg;
        marginRails_next = marginRails_reg;
        asserted_next = gpiTrue;
        evtPrev_next = evtVec;
        debug_next = debugAct;
        latchClear_next = clearAct;
        // Margin direction only matters while enable is asserted
        railMarg_next = menAct ? marginRails_reg : 32'h0000_0000;
        marginLow_next = menAct ? mdirAct : marginLow_reg;
        // Log sees new events, response all present events, only outside debug
        log_next = debugAct ? 18'h0_0000 : (evtVec & ~evtPrev_reg);
        resp_next = debugAct ? 18'h0_0000 : evtVec;
        alert_next = ((|evtVec) && !debugAct) || cmlError;
        // Active-low true level drives low; active-high true level releases
        pinOe_next = fpinEn_reg & {32{anyFpinFault && !debugAct}} & ~polarity_reg;
        // Sticky events: set wins over any clear in the same cycle
        evtLatch_next = evtLatch_reg;
        if (clearAct) begin
            evtLatch_next = 18'h0_0000;
        end
        if (wrFire && wrAddr_next == gsf_pkg::OFS_EVT_LATCH) begin
            evtLatch_next = evtLatch_next & ~wrData_next[17:0];
        end
        evtLatch_next = evtLatch_next | evtVec;
        if (wrFire) begin
            case (wrAddr_next)
                gsf_pkg::OFS_POLARITY: polarity_next = mergeBytes(polarity_reg, wrData_next, wrStrb_next);
                gsf_pkg::OFS_FAULT_EN: faultEn_next = mergeBytes(faultEn_reg, wrData_next, wrStrb_next);
                gsf_pkg::OFS_ROLE: role_next = mergeBytes(role_reg, wrData_next, wrStrb_next);
                gsf_pkg::OFS_FPIN_EN: fpinEn_next = mergeBytes(fpinEn_reg, wrData_next, wrStrb_next);
                gsf_pkg::OFS_FPIN_RAILS: fpinRails_next = mergeBytes(fpinRails_reg, wrData_next, wrStrb_next);
                gsf_pkg::OFS_MARGIN_RAILS: marginRails_next = mergeBytes(marginRails_reg, wrData_next, wrStrb_next);
                default: begin
                end
            endcase
        end
    end

    // ==========================================
    // AXI4-Lite next state
    always_comb begin
        wrState_next = wrState_reg;
        wrAddr_next = wrAddr_reg;
        wrData_next = wrData_reg;
        wrStrb_next = wrStrb_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        case (wrState_reg)
            gsf_pkg::WR_IDLE: begin
                if (s_axi_awvalid) begin
                    wrAddr_next = s_axi_awaddr;
                end
                if (s_axi_wvalid) begin
                    wrData_next = s_axi_wdata;
                    wrStrb_next = s_axi_wstrb;
                end
                if (s_axi_awvalid && s_axi_wvalid) begin
                    wrState_next = gsf_pkg::WR_RESP;
                end else if (s_axi_awvalid) begin
                    wrState_next = gsf_pkg::WR_ADDR;
                end else if (s_axi_wvalid) begin
                    wrState_next = gsf_pkg::WR_DATA;
                end
            end
            gsf_pkg::WR_ADDR: begin
                if (s_axi_wvalid) begin
                    wrData_next = s_axi_wdata;
                    wrStrb_next = s_axi_wstrb;
                    wrState_next = gsf_pkg::WR_RESP;
                end
            end
            gsf_pkg::WR_DATA: begin
                if (s_axi_awvalid) begin
                    wrAddr_next = s_axi_awaddr;
                    wrState_next = gsf_pkg::WR_RESP;
                end
            end
            gsf_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    wrState_next = gsf_pkg::WR_IDLE;
                end
            end
            default: wrState_next = gsf_pkg::WR_IDLE;
        endcase
        wrFire = (wrState_next == gsf_pkg::WR_RESP) && (wrState_reg != gsf_pkg::WR_RESP);
        if (wrFire) begin
            bresp_next = (wrAddr_next <= gsf_pkg::OFS_EVT_LATCH && wrAddr_next[1:0] == 2'h0 &&
                          wrAddr_next != gsf_pkg::OFS_GPI_STATE) ? gsf_pkg::RESP_OKAY : gsf_pkg::RESP_SLVERR;
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (!rvalid_reg && s_axi_arvalid) begin
            rvalid_next = 1'b1;
            rresp_next = gsf_pkg::RESP_OKAY;
            case (s_axi_araddr)
                gsf_pkg::OFS_POLARITY: rdata_next = polarity_reg;
                gsf_pkg::OFS_FAULT_EN: rdata_next = faultEn_reg;
                gsf_pkg::OFS_ROLE: rdata_next = role_reg;
                gsf_pkg::OFS_FPIN_EN: rdata_next = fpinEn_reg;
                gsf_pkg::OFS_FPIN_RAILS: rdata_next = fpinRails_reg;
                gsf_pkg::OFS_MARGIN_RAILS: rdata_next = marginRails_reg;
                gsf_pkg::OFS_GPI_STATE: rdata_next = asserted_reg;
                gsf_pkg::OFS_EVT_LATCH: rdata_next = {14'h0000, evtLatch_reg};
                gsf_pkg::OFS_MODE: rdata_next = {29'h0000_0000, marginLow_reg, |railMarg_reg, debug_reg};
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = gsf_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            polarity_reg <= gsf_pkg::POLARITY_RST;
            faultEn_reg <= gsf_pkg::ZERO_RST;
            role_reg <= gsf_pkg::ZERO_RST;
            fpinEn_reg <= gsf_pkg::ZERO_RST;
            fpinRails_reg <= gsf_pkg::ZERO_RST;
            marginRails_reg <= gsf_pkg::ZERO_RST;
            evtLatch_reg <= 18'h0_0000;
            evtPrev_reg <= 18'h0_0000;
            syncA_reg <= gsf_pkg::ZERO_RST;
            syncB_reg <= gsf_pkg::ZERO_RST;
            asserted_reg <= gsf_pkg::ZERO_RST;
            pinOe_reg <= gsf_pkg::ZERO_RST;
            railMarg_reg <= gsf_pkg::ZERO_RST;
            marginLow_reg <= 1'b0;
            latchClear_reg <= 1'b0;
            debug_reg <= 1'b0;
            alert_reg <= 1'b0;
            log_reg <= 18'h0_0000;
            resp_reg <= 18'h0_0000;
            wrState_reg <= gsf_pkg::WR_IDLE;
            wrAddr_reg <= 8'h00;
            wrData_reg <= gsf_pkg::ZERO_RST;
            wrStrb_reg <= 4'h0;
            bresp_reg <= gsf_pkg::RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= gsf_pkg::ZERO_RST;
            rresp_reg <= gsf_pkg::RESP_OKAY;
        end else begin
            polarity_reg <= polarity_next;
            faultEn_reg <= faultEn_next;
            role_reg <= role_next;
            fpinEn_reg <= fpinEn_next;
            fpinRails_reg <= fpinRails_next;
            marginRails_reg <= marginRails_next;
            evtLatch_reg <= evtLatch_next;
            evtPrev_reg <= evtPrev_next;
            syncA_reg <= gpiPinIn;
            syncB_reg <= syncA_reg;
            asserted_reg <= asserted_next;
            pinOe_reg <= pinOe_next;
            railMarg_reg <= railMarg_next;
            marginLow_reg <= marginLow_next;
            latchClear_reg <= latchClear_next;
            debug_reg <= debug_next;
            alert_reg <= alert_next;
            log_reg <= log_next;
            resp_reg <= resp_next;
            wrState_reg <= wrState_next;
            wrAddr_reg <= wrAddr_next;
            wrData_reg <= wrData_next;
            wrStrb_reg <= wrStrb_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ==========================================
    // Outputs
    assign s_axi_awready = (wrState_reg == gsf_pkg::WR_IDLE) || (wrState_reg == gsf_pkg::WR_DATA);
    assign s_axi_wready = (wrState_reg == gsf_pkg::WR_IDLE) || (wrState_reg == gsf_pkg::WR_ADDR);
    assign s_axi_bvalid = (wrState_reg == gsf_pkg::WR_RESP);
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    // Open-drain: only low is ever driven
    assign gpiPinOut = gsf_pkg::ZERO_RST;
    assign gpiPinOe = pinOe_reg;
    assign alertReq = alert_reg;
    assign logEvents = log_reg;
    assign respondEvents = resp_reg;
    assign railMargined = railMarg_reg;
    assign marginLow = marginLow_reg;
    assign latchClear = latchClear_reg;
    assign debugActive = debug_reg;
    assign gpiAsserted = asserted_reg;

endmodule

// File: tb/gsf_gpi_special_asserts.sv
module gsf_gpi_special_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [31:0] gpiPinOut,
    input wire logic [31:0] gpiPinOe,
    input wire gsf_pkg::gsf_event_type railEvents,
    input wire logic cmlError,
    input wire logic alertReq,
    input wire gsf_pkg::gsf_event_type logEvents,
    input wire gsf_pkg::gsf_event_type respondEvents,
    input wire logic debugActive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // ==========================================
    // Alert and event paths
    property p_cmlAlert;
        cmlError |=> alertReq;
    endproperty
    a_cmlAlert: assert property (p_cmlAlert) else $error("comm error did not alert");
    property p_dbgAlert;
        debugActive && $past(debugActive) && !$past(cmlError) |-> !alertReq;
    endproperty
    a_dbgAlert: assert property (p_dbgAlert) else $error("alert raised in debug");
    property p_alertAny;
        !debugActive && !$past(debugActive) && ($past(railEvents) != '0) |-> alertReq;
    endproperty
    a_alertAny: assert property (p_alertAny) else $error("event did not alert");
    property p_dbgLog;
        debugActive && $past(debugActive) |-> logEvents == '0;
    endproperty
    a_dbgLog: assert property (p_dbgLog) else $error("event logged in debug");
    property p_dbgResp;
        debugActive && $past(debugActive) |-> respondEvents == '0;
    endproperty
    a_dbgResp: assert property (p_dbgResp) else $error("response taken in debug");
    property p_respCopy;
        !debugActive && !$past(debugActive) |->
            ((respondEvents ^ $past(railEvents)) & 18'h3_f7ff) == 18'h0_0000;
    endproperty
    a_respCopy: assert property (p_respCopy) else $error("response does not follow events");
    property p_logRise;
        $rose(railEvents.seuDetected) && !debugActive ##1 !debugActive |-> logEvents.seuDetected;
    endproperty
    a_logRise: assert property (p_logRise) else $error("new event not logged");
    property p_logPulse;
        logEvents.turn_on_time_limit_fault |=> !logEvents.turn_on_time_limit_fault;
    endproperty
    a_logPulse: assert property (p_logPulse) else $error("log entry repeated");

    // ==========================================
    // Open-drain pins
    property p_odOut;
        gpiPinOut == '0;
    endproperty
    a_odOut: assert property (p_odOut) else $error("pin driven high");
    property p_dbgOe;
        debugActive && $past(debugActive) |-> gpiPinOe == '0;
    endproperty
    a_dbgOe: assert property (p_dbgOe) else $error("fault bus pulled in debug");
endmodule

bind gsf_gpi_special gsf_gpi_special_chk u_gsf_gpi_special_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .gpiPinOut(gpiPinOut), .gpiPinOe(gpiPinOe),
    .railEvents(railEvents), .cmlError(cmlError), .alertReq(alertReq), .logEvents(logEvents),
    .respondEvents(respondEvents), .debugActive(debugActive)
);

// File: tb/gsf_board_model.sv
module gsf_board_model (
    input wire logic [31:0] boardLevel,
    input wire logic [31:0] gpiPinOut,
    input wire logic [31:0] gpiPinOe,
    output logic [31:0] gpiPinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released fault bus lines sit at the board pull-up level
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            gpiPinIn[i] = gpiPinOe[i] ? gpiPinOut[i] : boardLevel[i];
        end
    end
endmodule

// File: tb/gsf_gpi_special_bench.sv
module gsf_gpi_special_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, boardLevel = 32'h0, railFault = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, gpiPinIn, gpiPinOut, gpiPinOe, railMargined, gpiAsserted;
    gsf_pkg::gsf_event_type railEvents = 18'h0;
    gsf_pkg::gsf_event_type logEvents, respondEvents;
    logic cmlError = 1'b0;
    logic alertReq, marginLow, latchClear, debugActive;
    int bad_count = 0;
    int total_checks = 0;

    always #5 core_clk = ~core_clk;

    gsf_gpi_special u_gsf_gpi_special (
        .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .gpiPinIn(gpiPinIn), .gpiPinOut(gpiPinOut), .gpiPinOe(gpiPinOe), .railFault(railFault),
        .railEvents(railEvents), .cmlError(cmlError), .alertReq(alertReq), .logEvents(logEvents),
        .respondEvents(respondEvents), .railMargined(railMargined), .marginLow(marginLow),
        .latchClear(latchClear), .debugActive(debugActive), .gpiAsserted(gpiAsserted)
    );
    gsf_board_model u_gsf_board_model (
        .boardLevel(boardLevel), .gpiPinOut(gpiPinOut), .gpiPinOe(gpiPinOe), .gpiPinIn(gpiPinIn)
    );

    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(er));
        if (n == 50) begin
            bad_count++;
            tally_and_finish();
        end
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed);
        check(32'(s_axi_rresp), 32'(er));
        if (n == 50) begin
            bad_count++;
            tally_and_finish();
        end
    endtask

    // Pin path takes four edges; six leaves margin
    task automatic pins(input logic [31:0] v);
        @(posedge core_clk);
        boardLevel <= v;
        repeat (6) @(posedge core_clk);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_registers();
        axi_read(gsf_pkg::OFS_POLARITY, gsf_pkg::POLARITY_RST, gsf_pkg::RESP_OKAY);
        axi_read(gsf_pkg::OFS_ROLE, gsf_pkg::ZERO_RST, gsf_pkg::RESP_OKAY);
        axi_write(gsf_pkg::OFS_MARGIN_RAILS, 32'h0000_00f0, gsf_pkg::RESP_OKAY);
        axi_read(gsf_pkg::OFS_MARGIN_RAILS, 32'h0000_00f0, gsf_pkg::RESP_OKAY);
        axi_write(gsf_pkg::OFS_GPI_STATE, 32'h0000_0001, gsf_pkg::RESP_SLVERR);
        axi_write(8'h40, 32'h0000_0001, gsf_pkg::RESP_SLVERR);
        axi_read(8'h40, 32'h0000_0000, gsf_pkg::RESP_SLVERR);
    endtask

    task automatic t_polarity();
        pins(32'h0000_0001);
        check(gpiAsserted, 32'h0000_0001);
        axi_write(gsf_pkg::OFS_POLARITY, 32'hffff_fffe, gsf_pkg::RESP_OKAY);
        pins(32'h0000_0001);
        check(gpiAsserted, 32'h0000_0000);
        pins(32'h0000_0000);
        check(gpiAsserted, 32'h0000_0001);
        axi_read(gsf_pkg::OFS_GPI_STATE, 32'h0000_0001, gsf_pkg::RESP_OKAY);
        axi_write(gsf_pkg::OFS_POLARITY, 32'hffff_ffff, gsf_pkg::RESP_OKAY);
    endtask

    task automatic t_roles();
        axi_write(gsf_pkg::OFS_ROLE, 32'h2423_2221, gsf_pkg::RESP_OKAY);
        pins(32'h0000_000c);
        check(railMargined, 32'h0000_00f0);
        check(32'(marginLow), 32'h1);
        axi_read(gsf_pkg::OFS_MODE, 32'h0000_0006, gsf_pkg::RESP_OKAY);
        pins(32'h0000_0004);
        check(32'(marginLow), 32'h0);
        pins(32'h0000_0000);
        check(railMargined, 32'h0000_0000);
        pins(32'h0000_0002);
        check(32'(latchClear), 32'h1);
    endtask

    task automatic t_events();
        // Pin 5 stays clear of the pin-selected state inputs
        axi_write(gsf_pkg::OFS_FAULT_EN, 32'h0000_0020, gsf_pkg::RESP_OKAY);
        pins(32'h0000_0000);
        check(32'(respondEvents.gpiDeasserted), 32'h1);
        check(32'(alertReq), 32'h1);
        pins(32'h0000_0020);
        for (int i = 0; i < 18; i++) begin
            if (i == 11) continue;
            @(posedge core_clk);
            railEvents <= gsf_pkg::gsf_event_type'(18'h1 << i);
            repeat (3) @(posedge core_clk);
            check(32'(respondEvents), 32'h1 << i);
            check(32'(alertReq), 32'h1);
        end
        axi_read(gsf_pkg::OFS_EVT_LATCH, 32'h0003_ffff, gsf_pkg::RESP_OKAY);
        // Upset event still present: it must survive the clear
        axi_write(gsf_pkg::OFS_EVT_LATCH, 32'h0003_ffff, gsf_pkg::RESP_OKAY);
        axi_read(gsf_pkg::OFS_EVT_LATCH, 32'h0002_0000, gsf_pkg::RESP_OKAY);
        // Debug on bring-up boards only; pin 1 keeps its clear role
        railEvents <= 18'h3ffff;
        pins(32'h0000_0012);
        check(32'(debugActive), 32'h1);
        check(32'(alertReq), 32'h0);
        check(32'(respondEvents), 32'h0);
        check(32'(logEvents), 32'h0);
        check(32'(latchClear), 32'h1);
        cmlError <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(32'(alertReq), 32'h1);
        cmlError <= 1'b0;
        railEvents <= 18'h0;
        pins(32'h0000_0020);
    endtask

    task automatic t_faultpin();
        axi_write(gsf_pkg::OFS_POLARITY, 32'hffff_ffbf, gsf_pkg::RESP_OKAY);
        axi_write(gsf_pkg::OFS_FPIN_EN, 32'h0000_0040, gsf_pkg::RESP_OKAY);
        axi_write(gsf_pkg::OFS_FPIN_RAILS, 32'h0000_0001, gsf_pkg::RESP_OKAY);
        pins(32'h0000_0060);
        check(gpiPinOe, 32'h0000_0000);
        railFault <= 32'h0000_0002;
        pins(32'h0000_0060);
        check(gpiPinOe, 32'h0000_0000);
        railFault <= 32'h0000_0001;
        pins(32'h0000_0060);
        check(gpiPinOe, 32'h0000_0040);
        check(gpiPinIn & 32'h0000_0040, 32'h0000_0000);
        pins(32'h0000_0070);
        check(gpiPinOe, 32'h0000_0000);
        railFault <= 32'h0000_0000;
        pins(32'h0000_0060);
        check(gpiPinOe, 32'h0000_0000);
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_registers();
        t_polarity();
        t_roles();
        t_events();
        t_faultpin();
        tally_and_finish();
    end
endmodule
